// ### cbbic_burst_index.sv
// double-word index within an aligned 16-byte block, wrap-around order
// assumes load and step never coincide
`timescale 1ns/1ps
module cbbic_burst_index (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire logic [1:0] start_dw,
    input wire logic step,
    output logic [1:0] dw,
    output logic [1:0] steps
);
    logic [1:0] dw_reg;
    logic [1:0] steps_reg;

    // two-bit index wraps naturally inside the block
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            dw_reg <= 2'h0;
            steps_reg <= 2'h0;
        end
        else if (load)
        begin
            dw_reg <= start_dw;
            steps_reg <= 2'h0;
        end
        else if (step)
        begin
            dw_reg <= dw_reg + 2'h1;
            steps_reg <= steps_reg + 2'h1;
        end
    end

    assign dw = dw_reg;
    assign steps = steps_reg;
endmodule

// ### cbbic_bus_divider.sv
// bus clock divider: phase enables for the sequencer
// assumes DIV is even and at least 2
`timescale 1ns/1ps
module cbbic_bus_divider #(
    parameter int DIV = cbbic_pkg::BUS_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    output logic tick_mid,
    output logic tick_end,
    output logic first_half
);
    localparam int CW = $clog2(DIV);
    localparam logic [CW-1:0] HALF = CW'(DIV / 2 - 1);
    localparam logic [CW-1:0] LAST = CW'(DIV - 1);
    logic [CW-1:0] cnt_reg;

    // free running phase counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= '0;
        else if (cnt_reg == LAST)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_reg + 1'b1;
    end

    // mid edge stands for the falling bus clock edge
    assign tick_mid = (cnt_reg == HALF);
    assign tick_end = (cnt_reg == LAST);
    assign first_half = (cnt_reg <= HALF);
endmodule

// ### cbbic_mem_model.sv
// memory side model: answers bus cycles with address-derived data
// assumes one pclk domain; slow mode adds wait states via ready
`timescale 1ns/1ps
module cbbic_mem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic slow,
    input wire logic refuse_burst,
    input wire logic [31:0] addr,
    output logic ready_n,
    output logic accept_n,
    output logic [31:0] rdata,
    output logic error_n,
    output logic retry_n,
    output logic [1:0] width,
    output logic inhibit,
    output logic io_n
);
    logic [2:0] cnt_reg;
    // free-running count makes irregular waits in slow mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= 3'h0;
        else
            cnt_reg <= cnt_reg + 3'h1;
    end
    // ready inactive repeats the state
    assign ready_n = slow & (cnt_reg[2:1] != 2'h0);
    // low accepts a burst; high refuses it
    assign accept_n = refuse_burst;
    // data tied to address so wrap order is visible
    assign rdata = addr ^ 32'h5a5a0000;
    // plain 32-bit memory, never errors or retries
    assign error_n = 1'b1;
    assign retry_n = 1'b1;
    assign width = 2'h3;
    assign inhibit = 1'b0;
    assign io_n = 1'b1;
endmodule

// ### cbbic_pkg.sv
// constants and types shared by the bus cycle sequencer files
// assumes a single pclk domain; pin levels follow the bus side's polarity
package cbbic_pkg;
    // apb register offsets (byte addresses)
    localparam logic [11:0] CTRL_OFFSET = 12'h000;
    localparam logic [11:0] STAT_OFFSET = 12'h004;
    // control field positions and reset value
    localparam int CTRL_DC_EN_POS = 0;
    localparam int CTRL_DC_LOCK_POS = 1;
    localparam logic [1:0] CTRL_RESET = 2'h0;
    // bus status codes
    localparam logic [4:0] ST_IDLE = 5'h00;
    localparam logic [4:0] ST_INT_ACK = 5'h04;
    localparam logic [4:0] ST_EOI = 5'h06;
    localparam logic [4:0] ST_FETCH_SEQ = 5'h08;
    localparam logic [4:0] ST_FETCH_NSEQ = 5'h09;
    localparam logic [4:0] ST_DATA = 5'h0a;
    localparam logic [4:0] ST_RMW_RD = 5'h0b;
    localparam logic [4:0] ST_EA_RD = 5'h0c;
    localparam logic [1:0] ST_SLAVE_TOP = 2'h3;
    // bus width code meaning 32 bits
    localparam logic [1:0] WIDTH_32 = 2'h3;
    // pclk cycles per bus clock period
    localparam int BUS_DIV = 2;
    // double-words per aligned 16-byte block
    localparam int BLOCK_BEATS = 4;
    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ILK_PRE = 3'b001,
        S_T1 = 3'b010,
        S_T2 = 3'b011,
        S_T2B = 3'b100,
        S_ILK_POST = 3'b101
    } cbbic_state_type;
endpackage

// ### cbbic_sequencer.sv
// external bus cycle sequencer: bursts, waits, interlock, int cycles
// assumes core holds a request until req_ready; apb slave on pclk
`timescale 1ns/1ps
// Summary of operation
// - burst only fetches and data reads; never writes or slave cycles
// - opening cycle drives status and asserts burst request
// - burst accept is sampled at the mid edge of the second state
// - accept high ends cycle after second state, request drops at once
// - accept low with request still on enters burst phase
// - at most three burst nibbles, one data item each
// - nibble address has low bits zero, next double-word, all enables
// - fetch bursts unless address is last double-word of block
// - data bursts need cache on, unlocked, cacheable, not bit interlock
// - four double-words in wrap-around order end a data burst
// - instruction burst ends at block end or on flow change
// - accept off, retry, io or narrow width end the burst
// - bus error or cache inhibit never stop a burst
// - ready sampled each state end; inactive repeats; slave never waits
// - only values sampled in the last wait state count
// - reset terminates any cycle at once
// - interlock rises mid idle before read, falls mid idle after write
// - no other bus operation while interlocked
// - interlock released at least one clock between transactions
// - error on interlocked read skips write, drops interlock
// - cancelled interlocked read drops interlock before next cycle
// - interrupt cycles are single byte reads that never burst
// - cycle is two states, address strobe in first half of first
// - five-bit status, ack 00100, end of interrupt 00110
module cbbic_sequencer #(
    parameter int DIV = cbbic_pkg::BUS_DIV
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [4:0] req_status,
    input wire logic [31:0] req_addr,
    input wire logic req_write,
    input wire logic [3:0] req_be_n,
    input wire logic [31:0] req_wdata,
    input wire logic req_cacheable,
    input wire logic req_bit_ilk,
    input wire logic req_interlock,
    input wire logic req_ilk_last,
    input wire logic req_cancel,
    input wire logic flow_change,
    output logic ans_valid,
    output logic [31:0] ans_data,
    output logic ans_error,
    output logic ans_retry,
    output logic bus_clock_out,
    output logic [31:0] addr_out,
    output logic [3:0] byte_enable_n,
    output logic [4:0] bus_status_code,
    output logic addr_strobe_n,
    output logic bus_write_out,
    output logic [31:0] data_out,
    input wire logic [31:0] data_in,
    input wire logic ready_n_in,
    input wire logic burst_accept_in,
    input wire logic bus_error_in,
    input wire logic bus_retry_in,
    input wire logic [1:0] bus_width_in,
    input wire logic cache_inhibit_in,
    input wire logic io_decode_in,
    output logic burst_request_out,
    output logic interlock_out
);
    cbbic_pkg::cbbic_state_type state_reg;
    logic tick_mid, tick_end, first_half;
    logic [1:0] dw, steps;
    logic [1:0] ctrl_reg;
    logic [31:0] cur_addr_reg, data_out_reg, ans_data_reg;
    logic [4:0] cur_status_reg;
    logic [3:0] cur_be_n_reg;
    logic cur_write_reg, cur_ilk_reg, cur_last_reg, cur_burst_reg;
    logic burst_request_out_on_reg, ilk_on_reg, ilk_active_reg, ilk_skip_reg;
    logic flow_pend_reg, ans_valid_reg, ans_error_reg, ans_retry_reg;
    logic s_accept_reg, s_error_reg, s_retry_reg, s_io_reg, s_cinh_reg;
    logic [1:0] s_width_reg;
    logic [31:0] prdata_reg;
    logic is_fetch, is_dread, burst_ok, slave, done, take, skip_wr;
    logic go_burst, nib_last, cancel, ilk_fail, cur_fetch;

    cbbic_bus_divider #(.DIV(DIV)) u_div (
        .pclk(pclk),
        .presetn(presetn),
        .tick_mid(tick_mid),
        .tick_end(tick_end),
        .first_half(first_half)
    );

    cbbic_burst_index u_idx (
        .pclk(pclk),
        .presetn(presetn),
        .load(take),
        .start_dw(req_addr[3:2]),
        .step(done && (state_reg != cbbic_pkg::S_T1)),
        .dw(dw),
        .steps(steps)
    );

    // burst eligibility of the request being taken
    assign is_fetch = (req_status == cbbic_pkg::ST_FETCH_SEQ) ||
        (req_status == cbbic_pkg::ST_FETCH_NSEQ);
    assign is_dread = (req_status == cbbic_pkg::ST_DATA) ||
        (req_status == cbbic_pkg::ST_RMW_RD) ||
        (req_status == cbbic_pkg::ST_EA_RD);
    // interrupt codes fall in neither class, so they never burst
    assign burst_ok = !req_write &&
        ((is_fetch && (req_addr[3:2] != 2'h3)) ||
        (is_dread && ctrl_reg[cbbic_pkg::CTRL_DC_EN_POS] &&
        !ctrl_reg[cbbic_pkg::CTRL_DC_LOCK_POS] &&
        req_cacheable && !req_bit_ilk));
    assign slave = (cur_status_reg[4:3] == cbbic_pkg::ST_SLAVE_TOP);

    // request take: a plain request waits while interlocked
    assign take = tick_end && req_valid && !skip_wr &&
        (((state_reg == cbbic_pkg::S_IDLE) &&
        (ilk_active_reg ? req_interlock : !req_interlock)) ||
        (state_reg == cbbic_pkg::S_ILK_PRE));
    // interlocked write after a failed read is answered without a cycle
    assign skip_wr = tick_end && req_valid && req_interlock && req_write &&
        ilk_skip_reg && (state_reg == cbbic_pkg::S_IDLE);
    assign req_ready = take || skip_wr;
    assign cancel = tick_end && req_cancel && (state_reg == cbbic_pkg::S_T1);

    // slave cycles ignore ready
    assign done = tick_end && (!ready_n_in || slave) &&
        ((state_reg == cbbic_pkg::S_T2) || (state_reg == cbbic_pkg::S_T2B));
    // pins active low except width and cache inhibit
    assign go_burst = burst_request_out_on_reg && !s_accept_reg && s_retry_reg &&
        s_io_reg && (s_width_reg == cbbic_pkg::WIDTH_32) &&
        !flow_pend_reg;
    // error and cache inhibit deliberately absent here
    assign nib_last = (steps == 2'h3) ||
        (cur_fetch && (dw == 2'h3)) ||
        s_accept_reg || !s_retry_reg || flow_pend_reg;
    assign ilk_fail = cur_ilk_reg && !cur_write_reg && !s_error_reg;

    // plain net, not a function, so a new latched status is seen at once
    assign cur_fetch = (cur_status_reg == cbbic_pkg::ST_FETCH_SEQ) ||
        (cur_status_reg == cbbic_pkg::ST_FETCH_NSEQ);

    // bus state machine, one state per bus clock period
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= cbbic_pkg::S_IDLE;
        else if (tick_end)
        begin
            unique case (state_reg)
                cbbic_pkg::S_IDLE:
                    if (take)
                        state_reg <= cbbic_pkg::S_T1;
                    else if (req_valid && req_interlock && !ilk_active_reg &&
                        !skip_wr)
                        state_reg <= cbbic_pkg::S_ILK_PRE;
                cbbic_pkg::S_ILK_PRE:
                    if (take)
                        state_reg <= cbbic_pkg::S_T1;
                cbbic_pkg::S_T1:
                    if (cancel)
                        state_reg <= ilk_active_reg ?
                            cbbic_pkg::S_ILK_POST : cbbic_pkg::S_IDLE;
                    else
                        state_reg <= cbbic_pkg::S_T2;
                cbbic_pkg::S_T2, cbbic_pkg::S_T2B:
                    if (done)
                    begin
                        if ((state_reg == cbbic_pkg::S_T2) ? go_burst :
                            !nib_last)
                            state_reg <= cbbic_pkg::S_T2B;
                        else if (ilk_fail || (cur_ilk_reg && cur_last_reg))
                            state_reg <= cbbic_pkg::S_ILK_POST;
                        else
                            state_reg <= cbbic_pkg::S_IDLE;
                    end
                cbbic_pkg::S_ILK_POST:
                    state_reg <= cbbic_pkg::S_IDLE;
                default:
                    state_reg <= cbbic_pkg::S_IDLE;
            endcase
        end
    end

    // cycle attributes latched at take
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur_addr_reg <= 32'h0;
            cur_status_reg <= 5'h00;
            cur_be_n_reg <= 4'hf;
            cur_write_reg <= 1'b0;
            cur_ilk_reg <= 1'b0;
            cur_last_reg <= 1'b0;
            cur_burst_reg <= 1'b0;
            data_out_reg <= 32'h0;
        end
        else if (take)
        begin
            cur_addr_reg <= req_addr;
            cur_status_reg <= req_status;
            cur_be_n_reg <= req_be_n;
            cur_write_reg <= req_write;
            cur_ilk_reg <= req_interlock;
            cur_last_reg <= req_ilk_last;
            cur_burst_reg <= burst_ok;
            data_out_reg <= req_wdata;
        end
    end

    // burst request: on from the opening state, off when the burst ends
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            burst_request_out_on_reg <= 1'b0;
        else if (take)
            burst_request_out_on_reg <= burst_ok;
        else if (done && ((state_reg == cbbic_pkg::S_T2) ? !go_burst :
            nib_last))
            burst_request_out_on_reg <= 1'b0;
        else if (cancel)
            burst_request_out_on_reg <= 1'b0;
    end

    // control inputs caught at the mid edge; each wait state overwrites
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_accept_reg <= 1'b1;
            s_error_reg <= 1'b1;
            s_retry_reg <= 1'b1;
            s_io_reg <= 1'b1;
            s_cinh_reg <= 1'b0;
            s_width_reg <= cbbic_pkg::WIDTH_32;
        end
        else if (tick_mid && ((state_reg == cbbic_pkg::S_T2) ||
            (state_reg == cbbic_pkg::S_T2B)))
        begin
            s_accept_reg <= burst_accept_in;
            s_error_reg <= bus_error_in;
            s_retry_reg <= bus_retry_in;
            s_cinh_reg <= cache_inhibit_in;
            // width and io decode only count in the opening cycle
            if (state_reg == cbbic_pkg::S_T2)
            begin
                s_io_reg <= io_decode_in;
                s_width_reg <= bus_width_in;
            end
        end
    end

    // pending flow change ends the fetch burst at the next nibble end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flow_pend_reg <= 1'b0;
        else if (flow_change && (state_reg != cbbic_pkg::S_IDLE))
            flow_pend_reg <= 1'b1; // set beats clear
        else if (take || (state_reg == cbbic_pkg::S_IDLE))
            flow_pend_reg <= 1'b0;
    end

    // interlock pin and transaction tracking
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ilk_on_reg <= 1'b0;
            ilk_active_reg <= 1'b0;
        end
        else if (tick_mid && (state_reg == cbbic_pkg::S_ILK_PRE))
        begin
            ilk_on_reg <= 1'b1;
            ilk_active_reg <= 1'b1;
        end
        else if (tick_mid && (state_reg == cbbic_pkg::S_ILK_POST))
        begin
            // post idle always precedes the next pre idle
            ilk_on_reg <= 1'b0;
            ilk_active_reg <= 1'b0;
        end
    end

    // failed interlocked read: later writes of it are skipped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ilk_skip_reg <= 1'b0;
        else if (done && ilk_fail)
            ilk_skip_reg <= 1'b1;
        else if (skip_wr && req_ilk_last)
            ilk_skip_reg <= 1'b0;
    end

    // answers to the core, one pclk pulse per transfer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ans_valid_reg <= 1'b0;
            ans_data_reg <= 32'h0;
            ans_error_reg <= 1'b0;
            ans_retry_reg <= 1'b0;
        end
        else
        begin
            ans_valid_reg <= done || skip_wr;
            if (done)
            begin
                ans_data_reg <= data_in;
                ans_error_reg <= !s_error_reg;
                ans_retry_reg <= !s_retry_reg;
            end
            else if (skip_wr)
            begin
                ans_error_reg <= 1'b1;
                ans_retry_reg <= 1'b0;
            end
        end
    end

    // bus pins; nibbles force low bits and all byte lanes
    always_comb
    begin
        addr_out = 32'h0;
        byte_enable_n = 4'hf;
        bus_status_code = cbbic_pkg::ST_IDLE;
        if (state_reg == cbbic_pkg::S_T2B)
        begin
            addr_out = {cur_addr_reg[31:4], dw, 2'b00};
            byte_enable_n = 4'h0;
            bus_status_code = cur_status_reg;
        end
        else if ((state_reg == cbbic_pkg::S_T1) ||
            (state_reg == cbbic_pkg::S_T2))
        begin
            addr_out = cur_addr_reg;
            byte_enable_n = cur_be_n_reg;
            bus_status_code = cur_status_reg;
        end
    end

    assign addr_strobe_n = !((state_reg == cbbic_pkg::S_T1) &&
        first_half);
    assign bus_clock_out = first_half;
    assign bus_write_out = cur_write_reg &&
        ((state_reg == cbbic_pkg::S_T1) || (state_reg == cbbic_pkg::S_T2));
    assign data_out = data_out_reg;
    assign burst_request_out = !burst_request_out_on_reg;
    assign interlock_out = !ilk_on_reg;
    assign ans_valid = ans_valid_reg;
    assign ans_data = ans_data_reg;
    assign ans_error = ans_error_reg;
    assign ans_retry = ans_retry_reg;

    // apb: control register, read data caught in the setup phase
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_reg <= cbbic_pkg::CTRL_RESET;
        else if (psel && penable && pwrite &&
            (paddr == cbbic_pkg::CTRL_OFFSET))
            ctrl_reg <= pwdata[1:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_reg <= 32'h0;
        else if (psel && !penable)
        begin
            if (paddr == cbbic_pkg::CTRL_OFFSET)
                prdata_reg <= {30'h0, ctrl_reg};
            else if (paddr == cbbic_pkg::STAT_OFFSET)
                prdata_reg <= {26'h0, ilk_skip_reg, burst_request_out_on_reg,
                    ilk_active_reg, state_reg};
            else
                prdata_reg <= 32'h0;
        end
    end

    assign prdata = prdata_reg;
    assign pready = psel && penable; // zero wait states
    assign pslverr = psel && penable && (paddr != cbbic_pkg::CTRL_OFFSET) &&
        (paddr != cbbic_pkg::STAT_OFFSET);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_open_refused;
        (state_reg == cbbic_pkg::S_T2) && done && burst_request_out_on_reg && !go_burst;
    endsequence
    sequence s_wait_state;
        (state_reg == cbbic_pkg::S_T2) && tick_end && ready_n_in && !slave;
    endsequence

    a_burst_no_write: assert property (!burst_request_out |->
        !cur_write_reg && !slave)
        else $error("burst request on write or slave cycle");
    a_open_burst_request_out: assert property (((state_reg == cbbic_pkg::S_T1) &&
        cur_burst_reg) |-> !burst_request_out)
        else $error("burst request missing in opening cycle");
    a_refuse_drop: assert property (s_open_refused |=>
        burst_request_out && (state_reg != cbbic_pkg::S_T2B))
        else $error("burst not ended after refusal");
    a_nibble_addr: assert property ((state_reg == cbbic_pkg::S_T2B) |->
        (addr_out[1:0] == 2'b00) && (byte_enable_n == 4'h0))
        else $error("nibble address or enables wrong");
    a_burst_max: assert property (((state_reg == cbbic_pkg::S_T2B) &&
        done && (steps == 2'h3)) |=> (state_reg != cbbic_pkg::S_T2B))
        else $error("more than three nibbles");
    a_wait_repeat: assert property (s_wait_state |=>
        (state_reg == cbbic_pkg::S_T2) && !ans_valid)
        else $error("wait state not repeated");
    a_ilk_read_on: assert property (((state_reg == cbbic_pkg::S_T1) &&
        cur_ilk_reg && !cur_write_reg && !ilk_skip_reg) |-> !interlock_out)
        else $error("interlock not on at locked read");
    a_ilk_exclusive: assert property (((state_reg == cbbic_pkg::S_T1) &&
        !interlock_out) |-> cur_ilk_reg)
        else $error("plain cycle inside interlock");
    a_ilk_gap: assert property ($rose(interlock_out) |=>
        interlock_out)
        else $error("interlock released under one clock");
    a_fetch_edge: assert property ((take && is_fetch &&
        (req_addr[3:2] == 2'h3)) |=> !cur_burst_reg && burst_request_out)
        else $error("burst from last double-word");
endmodule

// ### cpu_bus_burst_interlock_cycles_tb.sv
// bench for the bus cycle sequencer: apb, bursts, waits, interlock
// assumes the memory model on the bus side and DIV of 2
`timescale 1ns/1ps
module cpu_bus_burst_interlock_cycles_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, q, ans_data, addr_out, rdata;
    logic pready, pslverr, e, req_ready, ans_valid, ans_error, ans_retry;
    logic req_valid = 0, req_write = 0, req_bit_ilk = 0, req_interlock = 0;
    logic req_ilk_last = 0, req_cancel = 0, flow_change = 0;
    logic req_cacheable = 1, slow = 0, refuse = 0;
    logic [4:0] req_status = 0, bus_status_code;
    logic [31:0] req_addr = 0, req_wdata = 0, data_out;
    logic [3:0] req_be_n = 0, byte_enable_n;
    logic rdy_n, acc_n, err_n, rty_n, inh, io_n, burst_request_out;
    logic bus_clock_out, addr_strobe_n, bus_write_out, interlock_out;
    logic [1:0] width;
    int err_count = 0, checked = 0, cyc = 0;
    localparam logic [31:0] MASK = 32'h5a5a0000;

    cbbic_sequencer #(.DIV(2)) i_cbbic_sequencer (.pclk(pclk),
        .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .req_valid(req_valid),
        .req_ready(req_ready), .req_status(req_status),
        .req_addr(req_addr), .req_write(req_write), .req_be_n(req_be_n),
        .req_wdata(req_wdata), .req_cacheable(req_cacheable),
        .req_bit_ilk(req_bit_ilk), .req_interlock(req_interlock),
        .req_ilk_last(req_ilk_last), .req_cancel(req_cancel),
        .flow_change(flow_change), .ans_valid(ans_valid),
        .ans_data(ans_data), .ans_error(ans_error), .ans_retry(ans_retry),
        .bus_clock_out(bus_clock_out), .addr_out(addr_out),
        .byte_enable_n(byte_enable_n), .bus_status_code(bus_status_code),
        .addr_strobe_n(addr_strobe_n), .bus_write_out(bus_write_out),
        .data_out(data_out), .data_in(rdata), .ready_n_in(rdy_n),
        .burst_accept_in(acc_n), .bus_error_in(err_n),
        .bus_retry_in(rty_n), .bus_width_in(width),
        .cache_inhibit_in(inh), .io_decode_in(io_n),
        .burst_request_out(burst_request_out),
        .interlock_out(interlock_out));
    cbbic_mem_model i_cbbic_mem_model (.pclk(pclk), .presetn(presetn),
        .slow(slow), .refuse_burst(refuse), .addr(addr_out),
        .ready_n(rdy_n), .accept_n(acc_n), .rdata(rdata), .error_n(err_n),
        .retry_n(rty_n), .width(width), .inhibit(inh), .io_n(io_n));

    initial forever #12.5 pclk = ~pclk;
    // hang guard well above the run length
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            final_report;
        end
    end
    task check(input logic [31:0] seen, exp, input string what);
        checked++;
        if (seen !== exp)
        begin
            $display("unexpected %s exp %h seen %h", what, exp, seen);
            err_count++;
        end
    endtask
    task final_report;
        $display("mismatches %0d of %0d checks", err_count, checked);
        if (err_count == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one apb transfer, held until pready at a rising edge
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk) penable <= 1;
        do @(posedge pclk); while (pready !== 1);
        q = prdata; e = pslverr;
        psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    // core request; n answers expected in wrap order, then no more
    task core(input logic [4:0] st, input logic [31:0] a,
        input logic w, lk, last, input int n);
        int k, j;
        logic [31:0] x;
        j = 0;
        req_status <= st; req_addr <= a; req_write <= w;
        req_interlock <= lk; req_ilk_last <= last; req_valid <= 1;
        do @(negedge pclk); while (req_ready !== 1);
        @(posedge pclk) req_valid <= 0;
        for (k = 0; k < n + 12; k++)
        begin
            @(negedge pclk);
            if (addr_strobe_n === 0)
                check({bus_status_code, bus_write_out}, {st, w}, "status");
            // every answer counts, so a surplus one drives n below zero
            if (ans_valid === 1)
            begin
                x = {a[31:4], a[3:2] + 2'(j), 2'h0} ^ MASK;
                if (!w)
                    check(ans_data, x, "ans_data");
                check(ans_error, 0, "ans_error");
                if (lk)
                    check(interlock_out, 0, "interlock_out");
                n--;
                j++;
                k = 0;
            end
        end
        check(n, 0, "answer count");
        check(burst_request_out, 1, "burst_request_out");
        @(posedge pclk);
    endtask

    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        apb(0, cbbic_pkg::STAT_OFFSET, 0);
        check(q, 0, "stat reset");
        apb(0, 12'h008, 0);
        check(q, 0, "unmapped read");
        check(e, 1, "unmapped error");
        apb(1, cbbic_pkg::CTRL_OFFSET, 1);
        apb(0, cbbic_pkg::CTRL_OFFSET, 0);
        check(q, 1, "ctrl readback");
        core(cbbic_pkg::ST_FETCH_NSEQ, 32'h200, 0, 0, 0, 4);
        core(cbbic_pkg::ST_FETCH_SEQ, 32'h20c, 0, 0, 0, 1);
        slow <= 1;
        core(cbbic_pkg::ST_DATA, 32'h104, 0, 0, 0, 4);
        slow <= 0;
        core(cbbic_pkg::ST_DATA, 32'h104, 1, 0, 0, 1);
        core(cbbic_pkg::ST_INT_ACK, 32'hfffffe00, 0, 0, 0, 1);
        refuse <= 1;
        core(cbbic_pkg::ST_EA_RD, 32'h300, 0, 0, 0, 1);
        refuse <= 0;
        apb(1, cbbic_pkg::CTRL_OFFSET, 3);
        core(cbbic_pkg::ST_RMW_RD, 32'h400, 0, 1, 0, 1);
        core(cbbic_pkg::ST_DATA, 32'h400, 1, 1, 1, 1);
        repeat (4) @(posedge pclk);
        check(interlock_out, 1, "interlock released");
        final_report;
    end
endmodule
